// ### dtc_training_cmd.sv
// Purpose: command decode, interval oscillator and preamble/calibration training
// Assumes: cs/ca and mode register port are synchronous to mclk
// Notes:   two data beats per clock, so a burst of sixteen takes eight clocks
`timescale 1ns/1ns
`include "dtc_params.svh"
module dtc_training_cmd (
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        clk_en,
    input  wire logic        cs,
    input  wire logic [5:0]  ca,
    input  wire logic        mr_wr,
    input  wire logic        mr_rd,
    input  wire logic [5:0]  mr_addr,
    input  wire logic [7:0]  mr_wdata,
    input  wire logic        osc_tick,
    output logic      [7:0]  mr_rdata,
    output logic             mr_rvalid,
    output logic      [15:0] dq_even,
    output logic      [15:0] dq_odd,
    output logic             dq_oe,
    output logic      [1:0]  dmi_even,
    output logic      [1:0]  dmi_odd,
    output logic             dmi_oe,
    output logic             dqs_t,
    output logic             dqs_c,
    output logic             dqs_oe,
    output logic             osc_running,
    output logic             zq_start,
    output logic             zq_latch
);
    // ****************************************
    // state
    // ****************************************
    dtc_pkg::dtc_dec_state_t dec_state;
    logic        op6_q;
    logic        cal_pending;
    logic [7:0]  training_control_register;
    logic [7:0]  osc_run_time_setting;
    logic [7:0]  calibration_pattern_a;
    logic [7:0]  calibration_pattern_b;
    logic [15:0] inv_mask;
    logic [7:0]  osc_count_low_byte;
    logic [7:0]  osc_count_high_byte;
    logic [15:0] osc_count;
    logic [7:0]  run_cnt;
    logic        osc_s1, osc_s2, osc_s3;
    logic [`DTC_RL_CYC-1:0] lat_pipe;
    logic [2:0]  beat_pair;
    logic        bursting;
    logic        preamble_on;
    logic [3:0]  sdo_cnt;
    // decoded one-cycle commands
    logic [6:0]  op_full;
    logic        mpc_done, cmd_start, cmd_stop, cmd_needs_cas;
    logic        launch, auto_stop, osc_edge, burst_go;
    logic [2:0]  pair_now;
    // ****************************************
    // command decode
    // ****************************************
    // operand six came on the first edge, the rest arrive now
    assign op_full  = {op6_q, ca};
    assign mpc_done = (dec_state == dtc_pkg::DTC_MPC_OP) && !cs && op6_q;
    assign cmd_start = mpc_done && (op_full == `DTC_OP_OSC_START);
    assign cmd_stop  = mpc_done && (op_full == `DTC_OP_OSC_STOP);
    assign cmd_needs_cas = mpc_done && ((op_full == `DTC_OP_RD_FIFO)
                        || (op_full == `DTC_OP_RD_CAL) || (op_full == `DTC_OP_WR_FIFO));
    // latency starts at the column command second edge
    assign launch = (dec_state == dtc_pkg::DTC_CAS_OP) && !cs && cal_pending;

    // two-edge decoder; anything unexpected falls back to idle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dec_state   <= dtc_pkg::DTC_IDLE;
            op6_q       <= 1'b0;
            cal_pending <= 1'b0;
        end else if (clk_en) begin
            case (dec_state)
                dtc_pkg::DTC_IDLE: begin
                    cal_pending <= 1'b0;
                    if (cs && (ca[4:0] == `DTC_CA_MPC)) begin
                        op6_q     <= ca[5];
                        dec_state <= dtc_pkg::DTC_MPC_OP;
                    end
                end
                dtc_pkg::DTC_MPC_OP: begin
                    // reserved codes and op6 low leave everything untouched
                    if (cmd_needs_cas) begin
                        cal_pending <= (op_full == `DTC_OP_RD_CAL);
                        dec_state   <= dtc_pkg::DTC_WAIT_CAS;
                    end else begin
                        dec_state <= dtc_pkg::DTC_IDLE;
                    end
                end
                dtc_pkg::DTC_WAIT_CAS: begin
                    // the column command must follow at once, else dropped
                    if (cs && (ca[4:0] == `DTC_CA_CAS2)) begin
                        dec_state <= dtc_pkg::DTC_CAS_OP;
                    end else begin
                        cal_pending <= 1'b0;
                        dec_state   <= dtc_pkg::DTC_IDLE;
                    end
                end
                dtc_pkg::DTC_CAS_OP: dec_state <= dtc_pkg::DTC_IDLE;
                default:             dec_state <= dtc_pkg::DTC_IDLE;
            endcase
        end
    end
    // impedance calibration pulses, engine lives elsewhere
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            zq_start <= 1'b0;
            zq_latch <= 1'b0;
        end else if (clk_en) begin
            zq_start <= mpc_done && (op_full == `DTC_OP_ZQ_START);
            zq_latch <= mpc_done && (op_full == `DTC_OP_ZQ_LATCH);
        end
    end
    // ****************************************
    // mode registers
    // ****************************************
    // writable settings; result bytes ignore writes
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            training_control_register <= 8'h00;
            osc_run_time_setting      <= 8'h00;
            calibration_pattern_a     <= 8'h00;
            calibration_pattern_b     <= 8'h00;
            inv_mask                  <= 16'h0000;
        end else if (clk_en && mr_wr) begin
            case (mr_addr)
                `DTC_MR_TRAIN_CTL: training_control_register <= mr_wdata;
                `DTC_MR_RUN_TIME:  osc_run_time_setting      <= mr_wdata;
                `DTC_MR_PAT_A:     calibration_pattern_a     <= mr_wdata;
                `DTC_MR_PAT_B:     calibration_pattern_b     <= mr_wdata;
                `DTC_MR_INV_LO:    inv_mask[7:0]             <= mr_wdata;
                `DTC_MR_INV_HI:    inv_mask[15:8]            <= mr_wdata;
                default:           ;
            endcase
        end
    end
    // read answer one clock later; unmapped reads as zero
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mr_rdata  <= 8'h00;
            mr_rvalid <= 1'b0;
        end else if (clk_en) begin
            mr_rvalid <= mr_rd;
            if (mr_rd) begin
                case (mr_addr)
                    `DTC_MR_TRAIN_CTL: mr_rdata <= training_control_register;
                    `DTC_MR_RUN_TIME:  mr_rdata <= osc_run_time_setting;
                    `DTC_MR_PAT_A:     mr_rdata <= calibration_pattern_a;
                    `DTC_MR_PAT_B:     mr_rdata <= calibration_pattern_b;
                    `DTC_MR_INV_LO:    mr_rdata <= inv_mask[7:0];
                    `DTC_MR_INV_HI:    mr_rdata <= inv_mask[15:8];
                    `DTC_MR_OSC_LO:    mr_rdata <= osc_count_low_byte;
                    `DTC_MR_OSC_HI:    mr_rdata <= osc_count_high_byte;
                    default:           mr_rdata <= 8'h00;
                endcase
            end
        end
    end
    // ****************************************
    // interval oscillator
    // ****************************************
    // ring oscillator output is asynchronous; only s2 and s3 feed logic
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
        end else if (clk_en) begin
            osc_s1 <= osc_tick;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
        end
    end
    assign osc_edge  = osc_s2 && !osc_s3;
    // zero run time disables the automatic stop
    assign auto_stop = osc_running && (osc_run_time_setting != 8'h00)
                    && ((run_cnt + 8'h01) == osc_run_time_setting);
    // count, stop and store; a stop that is not running is ignored
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            osc_running         <= 1'b0;
            osc_count           <= 16'h0000;
            run_cnt             <= 8'h00;
            osc_count_low_byte  <= 8'h00;
            osc_count_high_byte <= 8'h00;
        end else if (clk_en) begin
            if (cmd_start) begin
                osc_running <= 1'b1;
                osc_count   <= 16'h0000;
                run_cnt     <= 8'h00;
            end else if (osc_running && (cmd_stop || auto_stop)) begin
                osc_running         <= 1'b0;
                osc_count_low_byte  <= osc_count[7:0];
                osc_count_high_byte <= osc_count[15:8];
            end else if (osc_running) begin
                run_cnt <= run_cnt + 8'h01;
                // hold at all ones so overflow reads as the maximum
                if (osc_edge && (osc_count != `DTC_OSC_MAX)) begin
                    osc_count <= osc_count + 16'h0001;
                end
            end
        end
    end
    // ****************************************
    // preamble training mode
    // ****************************************
    // follow the training bit after a fixed delay inside the switch window
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            preamble_on <= 1'b0;
            sdo_cnt     <= 4'h0;
        end else if (clk_en) begin
            if (training_control_register[`DTC_PRE_TRAIN_BIT] == preamble_on) begin
                sdo_cnt <= 4'h0;
            end else if (sdo_cnt == 4'(`DTC_SDO_APPLY)) begin
                preamble_on <= training_control_register[`DTC_PRE_TRAIN_BIT];
                sdo_cnt     <= 4'h0;
            end else begin
                sdo_cnt <= sdo_cnt + 4'h1;
            end
        end
    end
    // ****************************************
    // calibration burst
    // ****************************************
    // read latency pipe, one stage per clock
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lat_pipe <= '0;
        end else if (clk_en) begin
            lat_pipe <= {lat_pipe[`DTC_RL_CYC-2:0], launch};
        end
    end
    assign burst_go = lat_pipe[`DTC_RL_CYC-1];
    // a new launch restarts at beat zero, so bursts join seamlessly
    assign pair_now = burst_go ? 3'h0 : beat_pair;
    // eight clocks of two beats: always sixteen, no other length
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bursting  <= 1'b0;
            beat_pair <= 3'h0;
        end else if (clk_en) begin
            if (burst_go) begin
                bursting  <= 1'b1;
                beat_pair <= 3'h1;
            end else if (bursting && (beat_pair == 3'h0)) begin
                bursting <= 1'b0;
            end else if (bursting) begin
                beat_pair <= (beat_pair == `DTC_BURST_LAST) ? 3'h0 : beat_pair + 3'h1;
            end
        end
    end
    // pattern bit for beat index: low eight from a, high eight from b
    function automatic logic pat_bit(input logic [3:0] beat,
                                     input logic [7:0] pa,
                                     input logic [7:0] pb);
        pat_bit = beat[3] ? pb[beat[2:0]] : pa[beat[2:0]];
    endfunction
    // data and mask pins; mask pins never see bus inversion
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dq_even  <= 16'h0000;
            dq_odd   <= 16'h0000;
            dq_oe    <= 1'b0;
            dmi_even <= 2'h0;
            dmi_odd  <= 2'h0;
            dmi_oe   <= 1'b0;
        end else if (clk_en) begin
            if (burst_go || (bursting && (beat_pair != 3'h0))) begin
                dq_even  <= {16{pat_bit({pair_now, 1'b0}, calibration_pattern_a,
                                        calibration_pattern_b)}} ^ inv_mask;
                dq_odd   <= {16{pat_bit({pair_now, 1'b1}, calibration_pattern_a,
                                        calibration_pattern_b)}} ^ inv_mask;
                dmi_even <= {2{pat_bit({pair_now, 1'b0}, calibration_pattern_a,
                                       calibration_pattern_b)}};
                dmi_odd  <= {2{pat_bit({pair_now, 1'b1}, calibration_pattern_a,
                                       calibration_pattern_b)}};
                dq_oe    <= 1'b1;
                dmi_oe   <= 1'b1;
            end else begin
                dq_oe  <= 1'b0;
                dmi_oe <= 1'b0;
            end
        end
    end

    // strobe: static low/high in mode, held high/low in bursts, no preamble
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dqs_t  <= 1'b0;
            dqs_c  <= 1'b1;
            dqs_oe <= 1'b0;
        end else if (clk_en) begin
            if (burst_go || (bursting && (beat_pair != 3'h0))) begin
                dqs_t  <= 1'b1;
                dqs_c  <= 1'b0;
                dqs_oe <= 1'b1;
            end else begin
                dqs_t  <= 1'b0;
                dqs_c  <= 1'b1;
                dqs_oe <= preamble_on;
            end
        end
    end
    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence s_cal_cmd;
        launch && clk_en;
    endsequence
    sequence s_burst;
        dq_oe [*8];
    endsequence
    property p_saturate;
        clk_en && osc_running && (osc_count == `DTC_OSC_MAX) && !cmd_start |=>
            (osc_count == `DTC_OSC_MAX);
    endproperty
    a_saturate: assert property (p_saturate) else $error("counter left max");
    property p_stop_store;
        clk_en && osc_running && cmd_stop && !cmd_start |=>
            ({osc_count_high_byte, osc_count_low_byte} == $past(osc_count)) && !osc_running;
    endproperty
    a_stop_store: assert property (p_stop_store) else $error("stop did not store");
    property p_auto_stop;
        clk_en && auto_stop && !cmd_start |=>
            !osc_running && ({osc_count_high_byte, osc_count_low_byte} == $past(osc_count));
    endproperty
    a_auto_stop: assert property (p_auto_stop) else $error("auto stop failed");
    property p_zero_runs;
        clk_en && osc_running && (osc_run_time_setting == 8'h00) && !cmd_stop |=> osc_running;
    endproperty
    a_zero_runs: assert property (p_zero_runs) else $error("oscillator stopped early");
    property p_entry;
        clk_en && $rose(training_control_register[`DTC_PRE_TRAIN_BIT]) && !launch && !bursting
            |-> ##[1:13] (dqs_oe && !dqs_t && dqs_c);
    endproperty
    a_entry: assert property (p_entry) else $error("strobe not parked");
    property p_exit;
        clk_en && $fell(training_control_register[`DTC_PRE_TRAIN_BIT]) |-> ##[1:13] !preamble_on;
    endproperty
    a_exit: assert property (p_exit) else $error("mode exit too slow");
    property p_latency;
        s_cal_cmd ##1 clk_en [*6] |-> ##1 dq_oe && dqs_oe;
    endproperty
    a_latency: assert property (p_latency) else $error("burst latency wrong");
    property p_length;
        s_cal_cmd ##1 clk_en [*7] |-> s_burst;
    endproperty
    a_length: assert property (p_length) else $error("burst shorter than 16");
    property p_invert;
        dq_oe |-> ((dq_even ^ inv_mask) == {8{dmi_even}}) && ((dq_odd ^ inv_mask) == {8{dmi_odd}});
    endproperty
    a_invert: assert property (p_invert) else $error("mask or inversion wrong");
    property p_nop;
        clk_en && (dec_state == dtc_pkg::DTC_MPC_OP) && !cs && !op6_q |=>
            (osc_running == $past(osc_running)) && (dec_state == dtc_pkg::DTC_IDLE);
    endproperty
    a_nop: assert property (p_nop) else $error("nop changed state");
endmodule // dtc_training_cmd

// ### dtc_params.svh
// Purpose: constants for the dram training command logic
// Assumes: one clock (controller CK) at 125 MHz, 8 ns period
// Notes:   included by bare name; definitions only
//
// How it works
// - oscillator count split into low/high bytes
// - stop command overwrites both result bytes
// - oscillator counter saturates at all ones
// - zero run time: run until stop
// - nonzero run time: auto stop, then store
// - training bit: strobe low/high, held static
// - no normal preamble; calibration burst like read
// - burst: eight bits pattern a, eight pattern b
// - invert mask flips pattern per pin
// - pattern on mask pins, never bus-inverted
// - back-to-back calibration reads give seamless bursts
// - mode exit within the switch delay
// - calibration burst length always sixteen
// - command: operand six first edge, rest second
// - operand six zero means no operation
// - latency counted from column command second edge
// - oscillator and impedance commands need no column command
// - operand encodings for each training command
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// mode register addresses and the training bit
`define DTC_MR_TRAIN_CTL   6'h0D
`define DTC_MR_INV_LO      6'h0F
`define DTC_MR_OSC_LO      6'h12
`define DTC_MR_OSC_HI      6'h13
`define DTC_MR_INV_HI      6'h14
`define DTC_MR_RUN_TIME    6'h17
`define DTC_MR_PAT_A       6'h20
`define DTC_MR_PAT_B       6'h28
`define DTC_PRE_TRAIN_BIT  1

// command encodings on ca[4:0] at the first edge
`define DTC_CA_MPC         5'h00
`define DTC_CA_CAS2        5'h12

// training operands
`define DTC_OP_RD_FIFO     7'h41
`define DTC_OP_RD_CAL      7'h43
`define DTC_OP_WR_FIFO     7'h47
`define DTC_OP_OSC_START   7'h4B
`define DTC_OP_OSC_STOP    7'h4D
`define DTC_OP_ZQ_START    7'h4F
`define DTC_OP_ZQ_LATCH    7'h51

// oscillator and burst
`define DTC_OSC_MAX        16'hFFFF
`define DTC_RL_CYC         6
`define DTC_BURST_LAST     3'h7

// mode switch delay, longest time rounds down
`define DTC_CLK_PERIOD_NS  8
`define DTC_SDO_MAX_NS     20
`define DTC_SDO_MAX_NCK    12
`define DTC_SDO_NS_CYC     (`DTC_SDO_MAX_NS / `DTC_CLK_PERIOD_NS)
`define DTC_SDO_CYC        ((`DTC_SDO_NS_CYC > `DTC_SDO_MAX_NCK) ? \
                            `DTC_SDO_NS_CYC : `DTC_SDO_MAX_NCK)
`define DTC_SDO_APPLY      (`DTC_SDO_CYC - 3)

`endif

// ### dtc_pkg.sv
// Purpose: types for the dram training command logic
// Assumes: nothing
// Notes:   never imported, used as dtc_pkg::name
package dtc_pkg;
    typedef enum logic [1:0] {
        DTC_IDLE,
        DTC_MPC_OP,
        DTC_WAIT_CAS,
        DTC_CAS_OP
    } dtc_dec_state_t;
endpackage

// ### dtc_ctrl_model.sv
// Purpose: memory controller model, commands and mode register access
// Assumes: every request is driven just after a rising mclk edge
// Notes:   idle mode register address and data lines show the inverse of their last value
`timescale 1ns/1ns
`include "dtc_params.svh"

module dtc_ctrl_model (
    input  wire logic       mclk,
    output logic            cs,
    output logic      [5:0] ca,
    output logic            mr_wr,
    output logic            mr_rd,
    output logic      [5:0] mr_addr,
    output logic      [7:0] mr_wdata
);
    // idle bus at time zero
    initial begin
        {cs, ca, mr_wr, mr_rd, mr_addr, mr_wdata} = '0;
    end

    // two-edge command; calibration adds the column command
    task automatic mpc(input logic [6:0] op);
        @(posedge mclk) cs <= 1'b1;
        ca <= {op[6], 5'h00};
        @(posedge mclk) cs <= 1'b0;
        ca <= op[5:0];
        @(posedge mclk);
        if (op == `DTC_OP_RD_CAL) begin // column command follows at once
            cs <= 1'b1;
            ca <= {1'b0, `DTC_CA_CAS2};
            @(posedge mclk) cs <= 1'b0;
            ca <= 6'h00; // operands low
            repeat (4) @(posedge mclk); // eight-clock spacing keeps bursts seamless
        end else begin
            ca <= 6'h00;
        end
    endtask

    // mode register access, one-cycle strobes
    task automatic mr_acc(input logic wr, input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk) mr_wr <= wr;
        mr_rd <= ~wr;
        mr_addr <= a;
        mr_wdata <= d;
        @(posedge mclk) {mr_wr, mr_rd} <= 2'b00;
        mr_addr <= ~a;
        mr_wdata <= ~d;
    endtask
endmodule // dtc_ctrl_model

// ### tb_dtc_training_cmd.sv
// Purpose: self-checking bench for the training command logic
// Assumes: 125 MHz mclk, async active-low reset
// Notes:   expected results queue up; a watcher pops one per result seen
`timescale 1ns/1ns
`include "dtc_params.svh"

module tb_dtc_training_cmd;
    logic        mclk, arst_n, clk_en, osc_tick, cs, mr_wr, mr_rd, mr_rvalid;
    logic [5:0]  ca, mr_addr;
    logic [7:0]  mr_wdata, mr_rdata, pa, pb;
    logic [15:0] dq_even, dq_odd, m;
    logic [1:0]  dmi_even, dmi_odd;
    logic        dq_oe, dmi_oe, dqs_t, dqs_c, dqs_oe, osc_running, zq_start, zq_latch;
    logic [7:0]  q_rd[$];
    logic [37:0] q_dq[$];
    int          n_mismatch, checks_done, n_zs, n_zl, run, maxrun, n;

    dtc_ctrl_model dtc_ctrl_model_inst (.mclk(mclk), .cs(cs), .ca(ca), .mr_wr(mr_wr),
        .mr_rd(mr_rd), .mr_addr(mr_addr), .mr_wdata(mr_wdata));
    dtc_training_cmd dtc_training_cmd_inst (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
        .cs(cs), .ca(ca), .mr_wr(mr_wr), .mr_rd(mr_rd), .mr_addr(mr_addr),
        .mr_wdata(mr_wdata), .osc_tick(osc_tick), .mr_rdata(mr_rdata),
        .mr_rvalid(mr_rvalid), .dq_even(dq_even), .dq_odd(dq_odd), .dq_oe(dq_oe),
        .dmi_even(dmi_even), .dmi_odd(dmi_odd), .dmi_oe(dmi_oe), .dqs_t(dqs_t),
        .dqs_c(dqs_c), .dqs_oe(dqs_oe), .osc_running(osc_running),
        .zq_start(zq_start), .zq_latch(zq_latch));

    task automatic check(input logic [37:0] seen, input logic [37:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // k rising ticks, then quiet so the synchroniser drains
    task automatic tick(input int k);
        repeat (2 * k) @(posedge mclk) osc_tick <= ~osc_tick;
        repeat (4) @(posedge mclk);
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        q_rd.push_back(exp);
        dtc_ctrl_model_inst.mr_acc(1'b0, a, 8'h00);
    endtask

    task automatic cal_burst;
        logic [15:0] p;
        p = {pb, pa};
        for (int j = 0; j < 8; j++)
            q_dq.push_back({m ^ {16{p[2*j]}}, m ^ {16{p[2*j+1]}}, {2{p[2*j]}},
                {2{p[2*j+1]}}, 2'b11});
        dtc_ctrl_model_inst.mpc(`DTC_OP_RD_CAL);
    endtask

    // ****************************************
    // clock, watchdog, output watcher
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // sequence needs under 1200 clocks; allow ten times that
    initial begin
        #100000;
        n_mismatch++;
        end_sim();
    end

    always @(posedge mclk) begin
        if (mr_rvalid === 1'b1)
            check(mr_rdata, q_rd.size() ? q_rd.pop_front() : 8'hXX);
        if (dq_oe === 1'b1)
            check({dq_even, dq_odd, dmi_even, dmi_odd, dqs_t, dmi_oe},
                q_dq.size() ? q_dq.pop_front() : 'x);
        run = (dq_oe === 1'b1) ? run + 1 : 0;
        if (run > maxrun) maxrun = run;
        n_zs += (zq_start === 1'b1);
        n_zl += (zq_latch === 1'b1);
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {arst_n, osc_tick, n_mismatch, checks_done, n_zs, n_zl, run, maxrun} = '0;
        clk_en = 1'b1;
        void'($urandom(31036));
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        #1 check({dqs_c, dqs_oe, dq_oe, osc_running}, 4'h8);
        rd(`DTC_MR_OSC_LO, 8'h00);
        // open-ended run stopped by command
        n = 256 + $urandom % 200; // well under the maximum, so the reading is kept
        dtc_ctrl_model_inst.mpc(`DTC_OP_OSC_START);
        repeat (4) @(posedge mclk);
        tick(n);
        dtc_ctrl_model_inst.mpc(`DTC_OP_OSC_STOP);
        repeat (8) @(posedge mclk); // readout delay
        rd(`DTC_MR_OSC_LO, n[7:0]);
        rd(`DTC_MR_OSC_HI, n[15:8]);
        // reserved code, no-op and a write to a result byte change nothing
        dtc_ctrl_model_inst.mpc(7'h45);
        dtc_ctrl_model_inst.mpc(7'h0D);
        dtc_ctrl_model_inst.mr_acc(1'b1, `DTC_MR_OSC_LO, 8'hA5);
        rd(`DTC_MR_OSC_LO, n[7:0]);
        rd(`DTC_MR_OSC_HI, n[15:8]);
        // automatic stop after sixty clocks; late ticks ignored
        dtc_ctrl_model_inst.mr_acc(1'b1, `DTC_MR_RUN_TIME, 8'h3C);
        repeat (8) @(posedge mclk); // no restart before readout delay
        dtc_ctrl_model_inst.mpc(`DTC_OP_OSC_START);
        repeat (4) @(posedge mclk);
        tick(10); // auto stop only, no stop command sent
        for (int k = 0; k < 80 && osc_running === 1'b1; k++) @(posedge mclk);
        #1 check(osc_running, 1'b0);
        tick(5);
        repeat (8) @(posedge mclk);
        rd(`DTC_MR_OSC_LO, 8'h0A);
        rd(`DTC_MR_OSC_HI, 8'h00);
        // impedance commands pulse without a column command
        dtc_ctrl_model_inst.mpc(`DTC_OP_ZQ_START);
        dtc_ctrl_model_inst.mpc(`DTC_OP_ZQ_LATCH);
        repeat (3) @(posedge mclk);
        check({n_zs[3:0], n_zl[3:0]}, 8'h11);
        // calibration bursts back to back
        pa = 8'($urandom);
        pb = 8'($urandom);
        m = 16'($urandom);
        dtc_ctrl_model_inst.mr_acc(1'b1, `DTC_MR_PAT_A, pa);
        dtc_ctrl_model_inst.mr_acc(1'b1, `DTC_MR_PAT_B, pb);
        dtc_ctrl_model_inst.mr_acc(1'b1, `DTC_MR_INV_LO, m[7:0]);
        dtc_ctrl_model_inst.mr_acc(1'b1, `DTC_MR_INV_HI, m[15:8]);
        cal_burst();
        cal_burst();
        repeat (12) @(posedge mclk);
        check(maxrun, 16);
        // preamble training: parked strobe, then exit
        dtc_ctrl_model_inst.mr_acc(1'b1, `DTC_MR_TRAIN_CTL, 8'h02);
        repeat (13) @(posedge mclk);
        #1 check({dqs_oe, dqs_t, dqs_c}, 3'b101);
        cal_burst(); // only calibration reads while in the mode
        repeat (12) @(posedge mclk);
        #1 check({dqs_oe, dqs_t, dqs_c}, 3'b101);
        dtc_ctrl_model_inst.mr_acc(1'b1, `DTC_MR_TRAIN_CTL, 8'h00);
        repeat (13) @(posedge mclk);
        #1 check({dqs_oe, dqs_t, dqs_c}, 3'b001);
        rd(6'h3F, 8'h00);
        repeat (4) @(posedge mclk);
        check(q_rd.size() + q_dq.size(), 0);
        end_sim();
    end
endmodule // tb_dtc_training_cmd
